// ### verilog/cli_interpreter.sv
// command list interpreter: fetches 64-bit entries and executes them
// assumes a memory read port answering with fetch_valid and a store port answering with store_ack
// Function
// (RULE_01) entry: code bits 31..28, address, data high
// (RULE_02) code bit three set: flow, flush fifo
// (RULE_03) local targets use address bits 25..0; immediate and indirect load stores use dst bits 26..0
// (RULE_04) address bit 27 selects host memory
// (RULE_05) loads write map; flow branches, calls
// (RULE_06) software builds list, programs start, finishes
// (RULE_07) flow destinations relative or absolute
// (RULE_08) jump taken if any selected condition
// (RULE_09) software appends, stops, saves counter
// (RULE_10) no-op entry executes as nothing
// (RULE_11) address, condition, link registers exposed
// (RULE_12) start cleared: finish command, then halt
// (RULE_13) bit 30 reads one when idle
// (RULE_14) command_code_field decode, reserved codes ignored
// (RULE_15) call saves next address; return uses it
// (RULE_16) sequential fetch advances eight bytes
//
// Implementation choice: the address-and-strobe port.
module cli_interpreter (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire cli_pkg::cli_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output cli_pkg::cli_fetch_req_t fetch_req,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_data,
  output cli_pkg::cli_store_req_t store_req,
  input wire logic store_ack,
  output logic fifo_flush
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    CLI_IDLE,
    CLI_FETCH_LO,
    CLI_FETCH_HI,
    CLI_EXEC,
    CLI_IMM_DATA,
    CLI_IND_SRC,
    CLI_IND_READ,
    CLI_STORE
  } cli_phase_t;

  typedef struct packed {
    cli_phase_t phase;
    logic start;
    logic [27:0] pc;
    logic [31:0] cond;
    logic [27:0] link;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] src;
    logic [31:0] count;
    logic [27:0] dst;
    logic pad;
    logic [31:0] rdata;
    cli_pkg::cli_fetch_req_t fetch;
    cli_pkg::cli_store_req_t store;
    logic flush;
  } cli_state_t;

  cli_state_t cur;
  cli_state_t nxt;

  logic [31:0] mem_rdata;

  // entry words are parked in a small buffer; high word of the entry at index 1
  cli_entry_mem #(
    .WIDTH(32),
    .DEPTH(4),
    .AW(2)
  ) u_entry_mem (
    .sys_clk(sys_clk),
    .wr(fetch_valid),
    .waddr({1'b0, cur.phase == CLI_FETCH_HI}),
    .wdata(fetch_data),
    .raddr(2'h1),
    .rdata(mem_rdata)
  );

  function automatic cli_pkg::cli_fetch_req_t fetch_at(input logic [27:0] a);
    cli_pkg::cli_fetch_req_t f;
    f.req = 1'b1;
    f.host = a[cli_pkg::CLI_HOST_BIT]; // RULE_04
    if (a[cli_pkg::CLI_HOST_BIT]) begin
      f.addr = a[cli_pkg::CLI_HOST_MSB:0]; // RULE_04
    end else begin
      f.addr = {1'b0, a[cli_pkg::CLI_LOCAL_MSB:0]}; // RULE_03
    end
    return f;
  endfunction : fetch_at

  // relative when address bit 0 is set, absolute otherwise
  function automatic logic [27:0] dest(input logic [31:0] lo, input logic [27:0] pc);
    logic [27:0] d;
    d = {lo[cli_pkg::CLI_ADDR_MSB:3], 3'b000};
    if (lo[cli_pkg::CLI_REL_BIT]) begin
      d = pc + d; // RULE_07
    end
    return d;
  endfunction : dest

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [3:0] code;
    logic [27:0] next_pc;
    nxt = cur;
    code = cur.lo[cli_pkg::CLI_CODE_MSB:cli_pkg::CLI_CODE_LSB]; // RULE_01
    next_pc = cur.pc + cli_pkg::CLI_ENTRY_BYTES; // RULE_16
    nxt.flush = 1'b0;
    nxt.fetch.req = 1'b0;
    nxt.store.req = 1'b0;

    // register port
    nxt.rdata = 32'h0000_0000;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        cli_pkg::CLI_OFS_PC: nxt.rdata = {cur.start, cur.phase == CLI_IDLE, 2'b00, cur.pc[27:3], 3'b000}; // RULE_11 RULE_13
        cli_pkg::CLI_OFS_COND: nxt.rdata = cur.cond; // RULE_11
        cli_pkg::CLI_OFS_LINK: nxt.rdata = {4'h0, cur.link[27:3], 3'b000}; // RULE_11
        default: nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_req.wr) begin
      if (reg_req.addr == cli_pkg::CLI_OFS_COND) begin
        nxt.cond = reg_req.wdata;
      end
      if (reg_req.addr == cli_pkg::CLI_OFS_PC) begin
        nxt.start = reg_req.wdata[cli_pkg::CLI_START_BIT];
        // counter is only reloaded while halted, running pc stays the hardware's
        if (cur.phase == CLI_IDLE) begin
          nxt.pc = {reg_req.wdata[27:3], 3'b000};
        end
      end
    end

    unique case (cur.phase)
      CLI_IDLE: begin
        if (cur.start) begin
          nxt.phase = CLI_FETCH_LO;
          nxt.fetch = fetch_at(cur.pc);
        end
      end
      CLI_FETCH_LO: begin
        if (fetch_valid) begin
          nxt.lo = fetch_data;
          nxt.phase = CLI_FETCH_HI;
          nxt.fetch = fetch_at(cur.pc + cli_pkg::CLI_WORD_BYTES);
        end
      end
      CLI_FETCH_HI: begin
        if (fetch_valid) begin
          nxt.hi = fetch_data; // RULE_01
          nxt.phase = CLI_EXEC;
        end
      end
      CLI_EXEC: begin
        nxt.pc = next_pc; // RULE_16
        nxt.phase = CLI_FETCH_LO;
        if (cur.lo[cli_pkg::CLI_FLOW_BIT]) begin
          nxt.flush = 1'b1; // RULE_02
        end
        unique case (cli_pkg::cli_code_t'(code)) // RULE_14
          cli_pkg::CLI_OP_LOAD_MEM, cli_pkg::CLI_OP_LOAD_REG: begin
            nxt.store.req = 1'b1; // RULE_05
            nxt.store.is_reg = code[0];
            nxt.store.host = cur.lo[cli_pkg::CLI_HOST_BIT];
            nxt.store.addr = cur.lo[cli_pkg::CLI_HOST_BIT] ? cur.lo[26:0] : {1'b0, cur.lo[25:0]}; // RULE_03 RULE_04
            nxt.store.data = cur.hi;
            nxt.store.be = (!code[0] && cur.lo[0]) ? {2'b00, cur.hi[31], cur.hi[30]} : 4'hF;
            nxt.phase = CLI_STORE;
          end
          cli_pkg::CLI_OP_LOAD_MEM_IMM, cli_pkg::CLI_OP_LOAD_REG_IMM: begin
            nxt.count = cur.hi;
            nxt.dst = {cur.lo[27:2], 2'b00};
            nxt.pad = cur.hi[0];
            nxt.phase = CLI_FETCH_LO;
            if (cur.hi != 32'h0000_0000) begin
              nxt.phase = CLI_IMM_DATA;
              nxt.fetch = fetch_at(next_pc); // RULE_16
            end
          end
          cli_pkg::CLI_OP_LOAD_MEM_IND, cli_pkg::CLI_OP_LOAD_REG_IND: begin
            nxt.dst = {cur.lo[27:2], 2'b00};
            nxt.phase = CLI_IND_SRC;
            nxt.fetch = fetch_at(next_pc);
          end
          cli_pkg::CLI_OP_FINISH: begin
            nxt.pc = cur.pc; // stays on finish so an append resumes there
            nxt.start = 1'b0;
            nxt.phase = CLI_IDLE;
          end
          cli_pkg::CLI_OP_GOTO: nxt.pc = dest(cur.lo, cur.pc); // RULE_05 RULE_07
          cli_pkg::CLI_OP_CALL: begin
            nxt.link = next_pc; // RULE_15
            nxt.pc = dest(cur.lo, cur.pc);
          end
          cli_pkg::CLI_OP_RETURN: nxt.pc = cur.link; // RULE_15
          cli_pkg::CLI_OP_COND_JUMP: begin
            if ((cur.hi & cur.cond) != 32'h0000_0000) begin
              nxt.pc = dest(cur.lo, cur.pc); // RULE_08
            end
          end
          // status test has no wait source here; no-op code and reserved codes fall through
          default: nxt.pc = next_pc; // RULE_10 RULE_14
        endcase
        if (!cur.start && nxt.phase == CLI_FETCH_LO) begin
          nxt.phase = CLI_IDLE; // RULE_12
        end else if (nxt.phase == CLI_FETCH_LO) begin
          nxt.fetch = fetch_at(nxt.pc);
        end
      end
      CLI_IMM_DATA: begin
        if (fetch_valid) begin
          nxt.pc = cur.pc + cli_pkg::CLI_WORD_BYTES;
          if (cur.count != 32'h0000_0000) begin
            nxt.store.req = 1'b1;
            nxt.store.is_reg = code[0];
            nxt.store.host = cur.dst[cli_pkg::CLI_HOST_BIT];
            nxt.store.addr = cur.dst[26:0];
            nxt.store.data = fetch_data;
            nxt.store.be = 4'hF;
            nxt.dst = cur.dst + cli_pkg::CLI_WORD_BYTES;
            nxt.count = cur.count - 32'h0000_0001;
            nxt.phase = CLI_STORE;
          end else begin
            nxt.pad = 1'b0;
            nxt.phase = CLI_STORE;
          end
        end
      end
      CLI_IND_SRC: begin
        // one request per word; a second one in flight would return a stray answer
        if (fetch_valid) begin
          nxt.count = fetch_data;
          nxt.src = mem_rdata;
          nxt.pc = next_pc; // RULE_16
          nxt.phase = CLI_IND_READ;
          if (fetch_data != 32'h0000_0000) begin
            nxt.fetch = fetch_at(mem_rdata[27:0]);
          end
        end
      end
      CLI_IND_READ: begin
        if (cur.count == 32'h0000_0000) begin
          nxt.phase = cur.start ? CLI_FETCH_LO : CLI_IDLE; // RULE_12
          nxt.fetch = fetch_at(cur.pc);
          nxt.fetch.req = cur.start;
        end else begin
          if (fetch_valid) begin
            nxt.store.req = 1'b1;
            nxt.store.is_reg = code[0];
            nxt.store.host = cur.dst[cli_pkg::CLI_HOST_BIT];
            nxt.store.addr = cur.dst[26:0];
            nxt.store.data = fetch_data;
            nxt.store.be = 4'hF;
            nxt.dst = cur.dst + cli_pkg::CLI_WORD_BYTES;
            nxt.src = cur.src + 32'h0000_0004;
            nxt.count = cur.count - 32'h0000_0001;
            nxt.phase = CLI_STORE;
          end
        end
      end
      CLI_STORE: begin
        nxt.store.req = cur.store.req && !store_ack;
        if (store_ack || !cur.store.req) begin
          nxt.store.req = 1'b0;
          if (code == cli_pkg::CLI_OP_LOAD_MEM_IND || code == cli_pkg::CLI_OP_LOAD_REG_IND) begin
            nxt.phase = CLI_IND_READ;
            if (cur.count != 32'h0000_0000) begin
              nxt.fetch = fetch_at(cur.src[27:0]);
            end
          end else if ((code == cli_pkg::CLI_OP_LOAD_MEM_IMM || code == cli_pkg::CLI_OP_LOAD_REG_IMM)
                       && (cur.count != 32'h0000_0000 || cur.pad)) begin
            nxt.phase = CLI_IMM_DATA;
            nxt.fetch = fetch_at(cur.pc);
          end else if (!cur.start) begin
            nxt.phase = CLI_IDLE; // RULE_12
          end else begin
            nxt.phase = CLI_FETCH_LO;
            nxt.fetch = fetch_at(cur.pc);
          end
        end
      end
    endcase
    // fetch request stays one cycle; the memory answers later with fetch_valid
    if (cur.fetch.req) begin
      nxt.fetch.req = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
      cur.phase <= CLI_IDLE;
      cur.pc <= cli_pkg::CLI_PC_RESET[27:0];
      cur.cond <= cli_pkg::CLI_COND_RESET;
      cur.link <= cli_pkg::CLI_LINK_RESET[27:0];
    end else begin
      cur <= nxt;
    end
  end

  assign reg_rdata = cur.rdata;
  assign fetch_req = cur.fetch;
  assign store_req = cur.store;
  assign fifo_flush = cur.flush;

endmodule : cli_interpreter

// ### verilog/cli_pkg.sv
// package for the command list interpreter: register map, entry fields, opcodes, bus carriers
// assumes a single 50 MHz clock domain and a one-cycle register port
package cli_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CLI_OFS_PC = 8'h18;
  localparam logic [7:0] CLI_OFS_COND = 8'h1C;
  localparam logic [7:0] CLI_OFS_LINK = 8'h20;
  localparam int CLI_START_BIT = 31;
  localparam int CLI_IDLE_BIT = 30;
  localparam int CLI_ADDR_MSB = 27;
  localparam logic [31:0] CLI_PC_RESET = 32'h0000_0000;
  localparam logic [31:0] CLI_COND_RESET = 32'h0000_0000;
  localparam logic [31:0] CLI_LINK_RESET = 32'h0000_0000;

  // ****************************************
  // entry layout
  // ****************************************
  localparam int CLI_CODE_MSB = 31;
  localparam int CLI_CODE_LSB = 28;
  localparam int CLI_FLOW_BIT = 31;
  localparam int CLI_HOST_BIT = 27;
  localparam int CLI_LOCAL_MSB = 25;
  localparam int CLI_HOST_MSB = 26;
  localparam int CLI_REL_BIT = 0;
  localparam logic [27:0] CLI_ENTRY_BYTES = 28'h000_0008;
  localparam logic [27:0] CLI_WORD_BYTES = 28'h000_0004;

  typedef enum logic [3:0] {
    CLI_OP_LOAD_MEM = 4'h0,
    CLI_OP_LOAD_REG = 4'h1,
    CLI_OP_LOAD_MEM_IMM = 4'h2,
    CLI_OP_LOAD_REG_IMM = 4'h3,
    CLI_OP_LOAD_MEM_IND = 4'h4,
    CLI_OP_LOAD_REG_IND = 4'h5,
    CLI_OP_STATUS_TEST = 4'h6,
    CLI_OP_RSV7 = 4'h7,
    CLI_OP_FINISH = 4'h8,
    CLI_OP_GOTO = 4'h9,
    CLI_OP_CALL = 4'hA,
    CLI_OP_RETURN = 4'hB,
    CLI_OP_COND_JUMP = 4'hC,
    CLI_OP_RSVD = 4'hD,
    CLI_OP_RSVE = 4'hE,
    CLI_OP_RSVF = 4'hF
  } cli_code_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cli_reg_req_t;

  // memory read port for fetching entries and source data
  typedef struct packed {
    logic req;
    logic host;
    logic [26:0] addr;
  } cli_fetch_req_t;

  // write port into the device address map
  typedef struct packed {
    logic req;
    logic is_reg;
    logic host;
    logic [26:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } cli_store_req_t;

endpackage : cli_pkg

// ### verilog/cli_entry_mem.sv
// small memory holding the list entry words being executed
// assumes synchronous use with one write port and one read port; read data comes out of a register
module cli_entry_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic sys_clk,
  input wire logic wr,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : cli_entry_mem

// ### verification/cli_checker.sv
// port checker for the command list interpreter
// assumes one sys_clk domain with async resetn
module cli_checker (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire cli_pkg::cli_reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire cli_pkg::cli_fetch_req_t fetch_req,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_data,
  input wire cli_pkg::cli_store_req_t store_req,
  input wire logic store_ack,
  input wire logic fifo_flush
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ****
  // last word fetched from an address with bit 2 clear: entry low words and data words
  // ****
  logic low_req;
  logic [31:0] entry_lo;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      low_req <= 1'b0;
      entry_lo <= 32'h0000_0000;
    end else begin
      if (fetch_req.req) low_req <= !fetch_req.addr[2];
      if (fetch_valid && low_req) entry_lo <= fetch_data;
    end
  end
  // ****
  // assertions
  // ****
  rdata_quiet_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  cond_echo_a: assert property ((reg_req.wr && reg_req.addr == cli_pkg::CLI_OFS_COND ##1
    reg_req.rd && reg_req.addr == cli_pkg::CLI_OFS_COND) |=> reg_rdata == $past(reg_req.wdata, 2))
    else $error("condition register did not read back");
  busy_read_a: assert property (reg_req.rd && reg_req.addr == cli_pkg::CLI_OFS_PC && fetch_valid
    |=> !reg_rdata[cli_pkg::CLI_IDLE_BIT])
    else $error("idle reported while fetching");
  flush_single_a: assert property (fifo_flush |=> !fifo_flush)
    else $error("flush longer than one cycle");
  flush_flow_a: assert property (fifo_flush |-> entry_lo[cli_pkg::CLI_FLOW_BIT])
    else $error("flush for an ordinary command");
  fetch_single_a: assert property (fetch_req.req |=> !fetch_req.req)
    else $error("fetch request longer than one cycle");
  store_hold_a: assert property (store_req.req && !store_ack
    |=> store_req.req && $stable(store_req.addr) && $stable(store_req.data))
    else $error("store request dropped or changed before ack");
  local_range_a: assert property (store_req.req && !store_req.host |-> !store_req.addr[26])
    else $error("local store beyond 64MB");
  cover property (fifo_flush);
  cover property (store_req.req && store_ack && store_req.host);
  cover property (fetch_valid ##1 fetch_req.req);
endmodule : cli_checker

bind cli_interpreter cli_checker cli_checker_u (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .fetch_req(fetch_req), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
  .store_req(store_req), .store_ack(store_ack), .fifo_flush(fifo_flush));

// ### verification/cli_mem_model.sv
// memory holding the command list; answers fetches and stores
// assumes one-cycle fetch pulses and store requests held until ack
module cli_mem_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire cli_pkg::cli_fetch_req_t fetch_req,
  output logic fetch_valid,
  output logic [31:0] fetch_data,
  input wire cli_pkg::cli_store_req_t store_req,
  output logic store_ack
);
  logic [31:0] mem [0:63];
  logic [5:0] idx;
  logic [1:0] wait_f;
  logic [1:0] wait_s;
  logic pend;
  logic slow;
  // load, no-op, rel goto, skipped load, jump, finish, call, finish, pad, host load, return,
  // immediate load with pad, finish, indirect copy with count entry, finish, copy source
  initial begin
    mem = '{0: 32'h1000_0040, 1: 32'hA5A5_0001, 2: 32'hC000_0000, 4: 32'h9000_0011,
      6: 32'h1000_0044, 7: 32'hDEAD_BEEF, 8: 32'hC000_0030, 9: 32'h0000_0100, 10: 32'h8000_0000,
      12: 32'hA000_0048, 14: 32'h8000_0000, 16: 32'h8000_0000, 18: 32'h0800_0010,
      19: 32'h1234_5678, 20: 32'hB000_0000, 22: 32'h3000_0050, 23: 32'h0000_0001, 24: 32'h0BAD_F00D,
      26: 32'h8000_0000, 28: 32'h4000_0200, 29: 32'h0000_00A0, 30: 32'h0000_0001, 32: 32'h8000_0000,
      40: 32'h5A5A_C3C3, default: 32'h0000_0000};
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fetch_valid <= 1'b0;
      fetch_data <= 32'h0000_0000;
      store_ack <= 1'b0;
      idx <= 6'h00;
      wait_f <= 2'h0;
      wait_s <= 2'h0;
      pend <= 1'b0;
      slow <= 1'b0;
    end else begin
      fetch_valid <= 1'b0;
      store_ack <= 1'b0;
      // released data toggles so a stale sample never matches
      fetch_data <= ~fetch_data;
      if (fetch_req.req) begin
        pend <= 1'b1;
        idx <= fetch_req.addr[7:2];
        wait_f <= slow ? 2'h3 : 2'h0;
        slow <= ~slow;
      end else if (pend && wait_f != 2'h0) begin
        wait_f <= wait_f - 2'h1;
      end else if (pend) begin
        pend <= 1'b0;
        fetch_valid <= 1'b1;
        fetch_data <= mem[idx];
      end
      if (store_req.req && !store_ack) begin
        wait_s <= wait_s + 2'h1;
        if (wait_s == 2'h2) begin
          store_ack <= 1'b1;
          wait_s <= 2'h0;
        end
      end
    end
  end
endmodule : cli_mem_model

// ### verification/tb_top.sv
// self-checking bench for the command list interpreter
// assumes the memory model holds the list at address zero
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic resetn;
  cli_pkg::cli_reg_req_t reg_req;
  logic [31:0] reg_rdata;
  cli_pkg::cli_fetch_req_t fetch_req;
  logic fetch_valid;
  logic [31:0] fetch_data;
  cli_pkg::cli_store_req_t store_req;
  logic store_ack;
  logic fifo_flush;
  logic [31:0] rd_val;
  logic [60:0] stores [$];
  int errors = 0;
  int checks = 0;
  int flushes = 0;
  int cycles = 0;
  // each entry: is_reg, host, address, data
  localparam logic [60:0] exp_store [0:5] = '{{2'h2, 27'h40, 32'hA5A5_0001},
    {2'h1, 27'h10, 32'h1234_5678}, {2'h2, 27'h40, 32'hA5A5_0001}, {2'h2, 27'h40, 32'hA5A5_0001},
    {2'h2, 27'h50, 32'h0BAD_F00D}, {2'h0, 27'h200, 32'h5A5A_C3C3}};
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  cli_interpreter dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .fetch_req(fetch_req), .fetch_valid(fetch_valid), .fetch_data(fetch_data), .store_req(store_req),
    .store_ack(store_ack), .fifo_flush(fifo_flush));
  cli_mem_model mem_u (.sys_clk(sys_clk), .resetn(resetn), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .store_req(store_req), .store_ack(store_ack));
  // ****
  // monitors and tasks
  // ****
  always @(posedge sys_clk) begin
    cycles++;
    if (fifo_flush === 1'b1) flushes++;
    if (store_req.req === 1'b1 && store_ack === 1'b1) begin
      stores.push_back({store_req.is_reg, store_req.host, store_req.addr, store_req.data});
    end
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic wr_first);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: reg_req.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : reg_rd
  // polls until the list has stopped and reports idle
  task automatic run_wait();
    for (int i = 0; i < 300; i++) begin
      reg_rd(cli_pkg::CLI_OFS_PC, 1'b0);
      if (rd_val[31:30] === 2'h1) break;
    end
  endtask : run_wait
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // ****
  // tests
  // ****
  initial begin
    resetn = 1'b0;
    reg_req = '0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    reg_rd(cli_pkg::CLI_OFS_PC, 1'b0);
    chk(64'(rd_val), 64'h4000_0000);
    reg_rd(8'h30, 1'b0);
    chk(64'(rd_val), 64'h0);
    reg_wr(cli_pkg::CLI_OFS_LINK, 32'hFFFF_FFF8);
    reg_rd(cli_pkg::CLI_OFS_LINK, 1'b0);
    chk(64'(rd_val), 64'h0);
    // write then read with no gap
    @(posedge sys_clk);
    reg_req <= '{addr: cli_pkg::CLI_OFS_COND, wdata: 32'h0000_0100, wr: 1'b1, rd: 1'b0};
    reg_rd(cli_pkg::CLI_OFS_COND, 1'b1);
    chk(64'(rd_val), 64'h100);
    reg_wr(cli_pkg::CLI_OFS_PC, 32'h8000_0000);
    run_wait();
    chk(64'(rd_val), 64'h4000_0038);
    reg_rd(cli_pkg::CLI_OFS_LINK, 1'b0);
    chk(64'(rd_val), 64'h38);
    chk(64'(flushes), 64'h6);
    reg_wr(cli_pkg::CLI_OFS_COND, 32'h0000_0000);
    reg_wr(cli_pkg::CLI_OFS_PC, 32'h8000_0000);
    run_wait();
    chk(64'(rd_val), 64'h4000_0028);
    chk(64'(flushes), 64'hA);
    reg_wr(cli_pkg::CLI_OFS_PC, 32'h8000_0000);
    reg_wr(cli_pkg::CLI_OFS_PC, 32'h0000_0000);
    run_wait();
    chk(64'(rd_val), 64'h4000_0008);
    // restart from the counter read back, start bit set
    reg_wr(cli_pkg::CLI_OFS_PC, {1'b1, 3'h0, rd_val[27:0]});
    run_wait();
    chk(64'(rd_val), 64'h4000_0028);
    chk(64'(flushes), 64'hE);
    // immediate load with an odd count and pad word, then an indirect copy
    reg_wr(cli_pkg::CLI_OFS_PC, 32'h8000_0058);
    run_wait();
    chk(64'(rd_val), 64'h4000_0068);
    reg_wr(cli_pkg::CLI_OFS_PC, 32'h8000_0070);
    run_wait();
    chk(64'(rd_val), 64'h4000_0080);
    chk(64'(flushes), 64'h10);
    chk(64'(stores.size()), 64'h6);
    for (int k = 0; k < 6 && k < stores.size(); k++) chk(64'(stores[k]), 64'(exp_store[k]));
    end_of_test();
  end
endmodule : tb_top
